// *** src/eeprom_host_pkg.sv ***
// Constants shared by the parallel EEPROM host controller
package eeprom_host_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int PAGE_LSB = 7;
  localparam int PAGE_BYTES = 128;
  localparam int CLK_PERIOD_NS = 50;
  // Byte load interval, longest wait between falling write strobes
  localparam int BYTE_LOAD_NS = 100000;
  localparam int BYTE_LOAD_CYC = BYTE_LOAD_NS / CLK_PERIOD_NS;
  // Margin kept below the byte load interval
  localparam int LOAD_MARGIN_CYC = 100;
  // Setup and hold widths in cycles; the pulse lasts PULSE_CYC + 3 cycles
  localparam int SETUP_CYC = 2;
  localparam int PULSE_CYC = 4;
  localparam int HOLD_CYC = 2;
  // Typical programming time and polling limit
  localparam int PROG_NS = 3000000;
  localparam int PROG_CYC = PROG_NS / CLK_PERIOD_NS;
  localparam int POLL_LIMIT_CYC = 4 * PROG_CYC;
  localparam int CNT_W = 20;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_POLL = 2'h2;
endpackage

// *** src/bus_pins_if.sv ***
// Pin-level signals between the host sequencer and its pin stage
`timescale 1ns/1ns
interface bus_pins_if;
  logic [eeprom_host_pkg::ADDR_W-1:0] addr;
  logic [eeprom_host_pkg::DATA_W-1:0] wdata;
  logic chip_sel_n;
  logic out_drive_n;
  logic write_strobe_n;
  logic drive_data;
  logic [eeprom_host_pkg::DATA_W-1:0] rdata;
  modport ctrl (output addr, wdata, chip_sel_n, out_drive_n, write_strobe_n, drive_data,
                input rdata);
  modport pins (input addr, wdata, chip_sel_n, out_drive_n, write_strobe_n, drive_data,
                output rdata);
endinterface

// *** src/eeprom_pin_stage.sv ***
// Pin stage: registers strobes out and synchronises the data lines in
`timescale 1ns/1ns
module eeprom_pin_stage (
  input wire logic clk,
  input wire logic rst,
  bus_pins_if.pins bus,
  input wire logic [eeprom_host_pkg::DATA_W-1:0] data_in,
  output logic [eeprom_host_pkg::DATA_W-1:0] data_out,
  output logic [eeprom_host_pkg::DATA_W-1:0] data_oe_n,
  output logic [eeprom_host_pkg::ADDR_W-1:0] addr_out,
  output logic chip_sel_n,
  output logic out_drive_n,
  output logic write_strobe_n
);
  logic [eeprom_host_pkg::DATA_W-1:0] sync1;
  logic [eeprom_host_pkg::DATA_W-1:0] sync2;
  logic [eeprom_host_pkg::DATA_W-1:0] sync3;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_out <= '0;
      data_out <= '0;
      data_oe_n <= '1;
      chip_sel_n <= 1'b1;
      out_drive_n <= 1'b1;
      write_strobe_n <= 1'b1;
    end else begin
      addr_out <= bus.addr;
      data_out <= bus.wdata;
      // Never drive the data lines while the device may be driving them
      data_oe_n <= {eeprom_host_pkg::DATA_W{~bus.drive_data}};
      chip_sel_n <= bus.chip_sel_n;
      out_drive_n <= bus.out_drive_n;
      write_strobe_n <= bus.write_strobe_n;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      bus.rdata <= '0;
    end else begin
      sync1 <= data_in;
      sync2 <= sync1;
      sync3 <= sync2;
      // Accept a bit only once the last two stages agree
      for (int i = 0; i < eeprom_host_pkg::DATA_W; i++) begin
        if (sync2[i] == sync3[i]) begin
          bus.rdata[i] <= sync3[i];
        end
      end
    end
  end
endmodule

// *** src/eeprom_host.sv ***
// Host controller that reads, byte writes and page writes a parallel EEPROM
`timescale 1ns/1ns
module eeprom_host #(
  parameter int BYTE_LOAD_CYC = eeprom_host_pkg::BYTE_LOAD_CYC,
  parameter int POLL_LIMIT_CYC = eeprom_host_pkg::POLL_LIMIT_CYC
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic REQ_VALID,
  input wire logic [1:0] REQ_OP,
  input wire logic [eeprom_host_pkg::ADDR_W-1:0] REQ_ADDR,
  input wire logic [eeprom_host_pkg::DATA_W-1:0] REQ_DATA,
  input wire logic REQ_LAST,
  output logic REQ_READY,
  output logic RSP_VALID,
  output logic [eeprom_host_pkg::DATA_W-1:0] RSP_DATA,
  output logic RSP_ERROR,
  output logic WRITE_BUSY,
  output logic [eeprom_host_pkg::ADDR_W-1:0] EE_ADDR,
  input wire logic [eeprom_host_pkg::DATA_W-1:0] EE_DATA_IN,
  output logic [eeprom_host_pkg::DATA_W-1:0] EE_DATA_OUT,
  output logic [eeprom_host_pkg::DATA_W-1:0] EE_DATA_OE_N,
  output logic EE_CHIP_SEL_N,
  output logic EE_OUT_DRIVE_N,
  output logic EE_WRITE_STROBE_N
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_PULSE = 3'h2,
    ST_HOLD = 3'h3,
    ST_LOAD = 3'h4,
    ST_PROG = 3'h5
  } state_e;

  localparam int LOAD_OK_CYC = BYTE_LOAD_CYC - eeprom_host_pkg::LOAD_MARGIN_CYC;
  localparam int RD_SETTLE = eeprom_host_pkg::PULSE_CYC + 3;
  localparam logic [eeprom_host_pkg::CNT_W-1:0] CNT_ONE = 20'h00001;

  bus_pins_if bus ();

  state_e state;
  logic [1:0] op;
  logic last;
  logic in_page;
  logic [7:0] page_count;
  logic [eeprom_host_pkg::ADDR_W-eeprom_host_pkg::PAGE_LSB-1:0] page_select_bits;
  logic [eeprom_host_pkg::ADDR_W-1:0] byte_address;
  logic [eeprom_host_pkg::DATA_W-1:0] data_lines;
  logic [eeprom_host_pkg::DATA_W-1:0] prev_poll;
  logic have_prev;
  logic [eeprom_host_pkg::CNT_W-1:0] phase_cnt;
  logic [eeprom_host_pkg::CNT_W-1:0] gap_cnt;
  logic [eeprom_host_pkg::CNT_W-1:0] prog_cnt;

  function automatic logic page_match(input logic [eeprom_host_pkg::ADDR_W-1:0] a,
      input logic [eeprom_host_pkg::ADDR_W-eeprom_host_pkg::PAGE_LSB-1:0] p);
    page_match = (a[eeprom_host_pkg::ADDR_W-1:eeprom_host_pkg::PAGE_LSB] == p);
  endfunction

  logic accept_new;
  logic accept_load;
  assign accept_new = (state == ST_IDLE) && REQ_VALID;
  // A further page byte must share the page and fit the interval
  assign accept_load = (state == ST_LOAD) && REQ_VALID && (REQ_OP == eeprom_host_pkg::OP_WRITE)
      && page_match(REQ_ADDR, page_select_bits)
      && (page_count < 8'(eeprom_host_pkg::PAGE_BYTES))
      && (gap_cnt < eeprom_host_pkg::CNT_W'(LOAD_OK_CYC));

  // Request handshake and sequencer
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state <= ST_IDLE;
      op <= eeprom_host_pkg::OP_READ;
      last <= 1'b0;
      byte_address <= '0;
      data_lines <= '0;
      phase_cnt <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (REQ_VALID) begin
            op <= REQ_OP;
            last <= REQ_LAST;
            byte_address <= REQ_ADDR;
            data_lines <= REQ_DATA;
            phase_cnt <= '0;
            state <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          phase_cnt <= phase_cnt + CNT_ONE;
          if (phase_cnt + CNT_ONE >= eeprom_host_pkg::CNT_W'(eeprom_host_pkg::SETUP_CYC)) begin
            phase_cnt <= '0;
            state <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          phase_cnt <= phase_cnt + CNT_ONE;
          if (phase_cnt + CNT_ONE >= eeprom_host_pkg::CNT_W'(RD_SETTLE)) begin
            phase_cnt <= '0;
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          phase_cnt <= phase_cnt + CNT_ONE;
          if (phase_cnt + CNT_ONE >= eeprom_host_pkg::CNT_W'(eeprom_host_pkg::HOLD_CYC)) begin
            phase_cnt <= '0;
            if (op == eeprom_host_pkg::OP_WRITE) begin
              state <= last ? ST_PROG : ST_LOAD;
            end else if (op == eeprom_host_pkg::OP_POLL && WRITE_BUSY) begin
              state <= ST_SETUP;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_LOAD: begin
          if (accept_load) begin
            last <= REQ_LAST;
            byte_address <= REQ_ADDR;
            data_lines <= REQ_DATA;
            state <= ST_SETUP;
          end else if (gap_cnt >= eeprom_host_pkg::CNT_W'(LOAD_OK_CYC)) begin
            state <= ST_PROG;
          end
        end
        ST_PROG: begin
          // Poll the last byte written until the device finishes
          if (!WRITE_BUSY) begin
            state <= ST_IDLE;
          end else if (prog_cnt[3:0] == 4'hF) begin
            op <= eeprom_host_pkg::OP_POLL;
            state <= ST_SETUP;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Strobe generation: write strobe alone times the write so address
  // falls with it and data is taken as it rises
  always_comb begin
    bus.addr = byte_address;
    bus.wdata = data_lines;
    bus.chip_sel_n = !(state == ST_SETUP || state == ST_PULSE || state == ST_HOLD);
    bus.out_drive_n = 1'b1;
    bus.write_strobe_n = 1'b1;
    bus.drive_data = 1'b0;
    if (op == eeprom_host_pkg::OP_WRITE) begin
      bus.drive_data = !bus.chip_sel_n;
      bus.write_strobe_n = (state != ST_PULSE);
    end else begin
      bus.out_drive_n = (state != ST_PULSE) && (state != ST_HOLD);
    end
  end

  // Page tracking and the byte load interval
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      in_page <= 1'b0;
      page_count <= 8'h00;
      page_select_bits <= '0;
      gap_cnt <= '0;
    end else begin
      if (accept_new && REQ_OP == eeprom_host_pkg::OP_WRITE) begin
        in_page <= 1'b1;
        page_count <= 8'h01;
        page_select_bits <= REQ_ADDR[eeprom_host_pkg::ADDR_W-1:eeprom_host_pkg::PAGE_LSB];
      end else if (accept_load) begin
        page_count <= page_count + 8'h01;
      end else if (state == ST_PROG || state == ST_IDLE) begin
        in_page <= 1'b0;
      end
      // Interval runs from each falling write strobe
      if (state == ST_SETUP && op == eeprom_host_pkg::OP_WRITE
          && phase_cnt + CNT_ONE >= eeprom_host_pkg::CNT_W'(eeprom_host_pkg::SETUP_CYC)) begin
        gap_cnt <= '0;
      end else if (in_page && gap_cnt != '1) begin
        gap_cnt <= gap_cnt + CNT_ONE;
      end
    end
  end

  // Toggle and inverted-bit polling decide the end of programming
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      WRITE_BUSY <= 1'b0;
      prev_poll <= '0;
      have_prev <= 1'b0;
      prog_cnt <= '0;
      RSP_ERROR <= 1'b0;
    end else begin
      if (state == ST_HOLD && op == eeprom_host_pkg::OP_WRITE && last) begin
        WRITE_BUSY <= 1'b1;
        have_prev <= 1'b0;
        prog_cnt <= '0;
        RSP_ERROR <= 1'b0;
      end else if (state == ST_LOAD && !accept_load
          && gap_cnt >= eeprom_host_pkg::CNT_W'(LOAD_OK_CYC)) begin
        WRITE_BUSY <= 1'b1;
        have_prev <= 1'b0;
        prog_cnt <= '0;
        RSP_ERROR <= 1'b0;
      end else if (WRITE_BUSY) begin
        prog_cnt <= prog_cnt + CNT_ONE;
        if (prog_cnt >= eeprom_host_pkg::CNT_W'(POLL_LIMIT_CYC)) begin
          WRITE_BUSY <= 1'b0;
          RSP_ERROR <= 1'b1;
        end else if (state == ST_HOLD && op == eeprom_host_pkg::OP_POLL && phase_cnt == '0) begin
          prev_poll <= bus.rdata;
          have_prev <= 1'b1;
          // Finished once bit six holds still and bit seven matches the data written
          if (have_prev && bus.rdata[6] == prev_poll[6]
              && bus.rdata[7] == data_lines[7]) begin
            WRITE_BUSY <= 1'b0;
          end
        end
      end
    end
  end

  // Answers: ready and read data, all registered
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      REQ_READY <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_DATA <= '0;
    end else begin
      // Ready promises a take at the next edge, so it drops before the interval lapses
      REQ_READY <= (state == ST_IDLE && !REQ_VALID)
          || (state == ST_LOAD && !accept_load
          && gap_cnt + CNT_ONE < eeprom_host_pkg::CNT_W'(LOAD_OK_CYC));
      RSP_VALID <= 1'b0;
      if (state == ST_HOLD && phase_cnt == '0 && op == eeprom_host_pkg::OP_READ) begin
        RSP_VALID <= 1'b1;
        RSP_DATA <= bus.rdata;
      end
    end
  end

  eeprom_pin_stage u_pins (
    .clk(CORE_CLK),
    .rst(RST),
    .bus(bus.pins),
    .data_in(EE_DATA_IN),
    .data_out(EE_DATA_OUT),
    .data_oe_n(EE_DATA_OE_N),
    .addr_out(EE_ADDR),
    .chip_sel_n(EE_CHIP_SEL_N),
    .out_drive_n(EE_OUT_DRIVE_N),
    .write_strobe_n(EE_WRITE_STROBE_N)
  );
endmodule

// *** dv/eeprom_host_monitor.sv ***
// Pin-level checker for the EEPROM host controller
`timescale 1ns/1ns
module eeprom_host_monitor #(
  parameter int BYTE_LOAD_CYC = 2000
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic RSP_VALID,
  input wire logic WRITE_BUSY,
  input wire logic [14:0] EE_ADDR,
  input wire logic [7:0] EE_DATA_OUT,
  input wire logic [7:0] EE_DATA_OE_N,
  input wire logic EE_CHIP_SEL_N,
  input wire logic EE_OUT_DRIVE_N,
  input wire logic EE_WRITE_STROBE_N
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  logic loading;
  logic [7:0] pg;
  int gap;
  // Page is open from the first strobe until programming starts
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      loading <= 1'b0;
      pg <= 8'h00;
      gap <= 0;
    end else if ($rose(WRITE_BUSY)) begin
      loading <= 1'b0;
    end else if ($fell(EE_WRITE_STROBE_N)) begin
      loading <= 1'b1;
      pg <= EE_ADDR[14:7];
      gap <= 0;
    end else if (gap < 100000) begin
      gap <= gap + 1;
    end
  end
  property p_rd_cs; !EE_OUT_DRIVE_N |-> !EE_CHIP_SEL_N; endproperty
  a_rd_cs: assert property (p_rd_cs) else $error("read without select");
  property p_wr_cs; !EE_WRITE_STROBE_N |-> !EE_CHIP_SEL_N; endproperty
  a_wr_cs: assert property (p_wr_cs) else $error("strobe without select");
  property p_wr_oe; !EE_WRITE_STROBE_N |-> EE_OUT_DRIVE_N; endproperty
  a_wr_oe: assert property (p_wr_oe) else $error("strobe with output drive");
  property p_rd_hiz; !EE_OUT_DRIVE_N |-> EE_DATA_OE_N == 8'hFF; endproperty
  a_rd_hiz: assert property (p_rd_hiz) else $error("host drives during read");
  property p_wr_drive; !EE_WRITE_STROBE_N |-> EE_DATA_OE_N == 8'h00; endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("data not driven");
  property p_wr_stable;
    !EE_WRITE_STROBE_N && !$past(EE_WRITE_STROBE_N) |-> $stable(EE_ADDR) && $stable(EE_DATA_OUT);
  endproperty
  a_wr_stable: assert property (p_wr_stable) else $error("write moved");
  property p_we_width; $fell(EE_WRITE_STROBE_N) |-> !EE_WRITE_STROBE_N [*4]; endproperty
  a_we_width: assert property (p_we_width) else $error("strobe too short");
  property p_busy_nowr; WRITE_BUSY |-> EE_WRITE_STROBE_N; endproperty
  a_busy_nowr: assert property (p_busy_nowr) else $error("write in programming");
  property p_page; $fell(EE_WRITE_STROBE_N) && loading |-> EE_ADDR[14:7] == pg; endproperty
  a_page: assert property (p_page) else $error("page bits changed");
  property p_gap; $fell(EE_WRITE_STROBE_N) && loading |-> gap < BYTE_LOAD_CYC; endproperty
  a_gap: assert property (p_gap) else $error("load too late");
  property p_rsp_pulse; RSP_VALID |=> !RSP_VALID; endproperty
  a_rsp_pulse: assert property (p_rsp_pulse) else $error("response too long");
endmodule
bind eeprom_host eeprom_host_monitor #(.BYTE_LOAD_CYC(BYTE_LOAD_CYC)) i_eeprom_host_monitor (
  .CORE_CLK, .RST, .RSP_VALID, .WRITE_BUSY, .EE_ADDR, .EE_DATA_OUT, .EE_DATA_OE_N,
  .EE_CHIP_SEL_N, .EE_OUT_DRIVE_N, .EE_WRITE_STROBE_N);

// *** dv/eeprom_device_model.sv ***
// Behavioural model of the byte-wide parallel EEPROM
`timescale 1ns/1ns
module eeprom_device_model #(
  parameter int LOAD_NS = 15000,
  parameter int PROG_NS = 20000
) (
  input wire logic [14:0] addr,
  input wire logic chip_sel_n,
  input wire logic out_drive_n,
  input wire logic write_strobe_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic viol
);
  logic [7:0] mem [0:32767];
  logic [7:0] pbuf [0:127];
  logic [127:0] pvld;
  logic [14:0] wa;
  logic [7:0] last_d, page, q;
  logic loading = 1'b0;
  logic prog = 1'b0;
  logic tog = 1'b0;
  time t_fall = 0;
  wire rd = !chip_sel_n && !out_drive_n;
  wire wr = !chip_sel_n && !write_strobe_n && out_drive_n;
  initial begin
    viol = 1'b0;
    data_out = 8'h00;
    foreach (mem[i]) mem[i] = 8'hFF;
  end
  // Status shows from the first load, so a poll during loading never looks finished
  assign q = (prog || loading) ? {~last_d[7], tog, last_d[5:0]} : mem[addr];
  always @(posedge rd) if (prog || loading) tog = ~tog;
  // Released lines wander rather than keep the last value
  always @(rd or q) data_out = rd ? q : ~data_out;
  always @(negedge out_drive_n) if (!chip_sel_n && !write_strobe_n) viol = 1'b1;
  always @(posedge wr) begin
    if (!prog) begin
      wa = addr;
      t_fall = $time;
      if (!loading) begin
        loading = 1'b1;
        page = addr[14:7];
        pvld = '0;
      end else if (addr[14:7] != page) begin
        viol = 1'b1;
      end
    end
  end
  always @(negedge wr) begin
    if (loading && !prog) begin
      pbuf[wa[6:0]] = data_in;
      pvld[wa[6:0]] = 1'b1;
      last_d = data_in;
    end
  end
  initial forever begin
    #500;
    if (loading && $time - t_fall >= LOAD_NS) begin
      loading = 1'b0;
      prog = 1'b1;
      #PROG_NS;
      foreach (pbuf[i]) if (pvld[i]) mem[{page, i[6:0]}] = pbuf[i];
      prog = 1'b0;
    end
  end
endmodule

// *** dv/eeprom_host_test.sv ***
// Self-checking testbench for the EEPROM host controller
`timescale 1ns/1ns
module eeprom_host_test;
  logic CORE_CLK, RST, REQ_VALID, REQ_LAST, REQ_READY, RSP_VALID, RSP_ERROR, WRITE_BUSY;
  logic EE_CHIP_SEL_N, EE_OUT_DRIVE_N, EE_WRITE_STROBE_N, viol;
  logic [1:0] REQ_OP;
  logic [14:0] REQ_ADDR, EE_ADDR;
  logic [7:0] REQ_DATA, RSP_DATA, EE_DATA_OUT, EE_DATA_OE_N, dev_q;
  wire [7:0] EE_DATA_IN = (EE_DATA_OUT & ~EE_DATA_OE_N) | (dev_q & EE_DATA_OE_N);
  int bad_count = 0;
  int n_checks = 0;
  eeprom_host #(.BYTE_LOAD_CYC(300), .POLL_LIMIT_CYC(2000)) i_eeprom_host (
    .CORE_CLK, .RST, .REQ_VALID, .REQ_OP, .REQ_ADDR, .REQ_DATA, .REQ_LAST, .REQ_READY,
    .RSP_VALID, .RSP_DATA, .RSP_ERROR, .WRITE_BUSY, .EE_ADDR, .EE_DATA_IN, .EE_DATA_OUT,
    .EE_DATA_OE_N, .EE_CHIP_SEL_N, .EE_OUT_DRIVE_N, .EE_WRITE_STROBE_N);
  eeprom_device_model i_eeprom_device_model (.addr(EE_ADDR), .chip_sel_n(EE_CHIP_SEL_N),
    .out_drive_n(EE_OUT_DRIVE_N), .write_strobe_n(EE_WRITE_STROBE_N),
    .data_in(EE_DATA_IN), .data_out(dev_q), .viol(viol));
  initial begin
    CORE_CLK = 1'b0;
    forever #25 CORE_CLK = ~CORE_CLK;
  end
  task test_done;
    if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge CORE_CLK);
    #2;
  endtask
  task timed_out;
    bad_count++;
    $display("[ERR] %0t wait ran out", $time);
    test_done;
  endtask
  task send(input logic [1:0] op, input logic [14:0] a, input logic [7:0] d, input logic last);
    int i;
    // Offer only once ready stands; a held request would be taken again on return to idle
    for (i = 0; i < 4000 && REQ_READY !== 1'b1; i++) tick(1);
    if (i == 4000) timed_out;
    REQ_VALID = 1'b1;
    REQ_OP = op;
    REQ_ADDR = a;
    REQ_DATA = d;
    REQ_LAST = last;
    tick(1);
    REQ_VALID = 1'b0;
  endtask
  task rd(input logic [14:0] a, input logic [7:0] exp);
    int i;
    send(2'h0, a, 8'h00, 1'b0);
    for (i = 0; i < 100 && RSP_VALID !== 1'b1; i++) tick(1);
    if (i == 100) timed_out;
    check(RSP_DATA, exp);
  endtask
  task wait_busy(input logic lvl, input int lim);
    int i;
    for (i = 0; i < lim && WRITE_BUSY !== lvl; i++) tick(1);
    if (i == lim) timed_out;
  endtask
  task t_reset;
    check({5'h00, EE_CHIP_SEL_N, EE_OUT_DRIVE_N, EE_WRITE_STROBE_N}, 8'h07);
    check(EE_DATA_OE_N, 8'hFF);
    check({4'h0, REQ_READY, RSP_VALID, WRITE_BUSY, RSP_ERROR}, 8'h00);
    check(EE_DATA_OUT, 8'h00);
  endtask
  task t_byte;
    send(2'h1, 15'h7FFF, 8'hA5, 1'b1);
    wait_busy(1'b1, 400);
    wait_busy(1'b0, 3000);
    check({7'h00, RSP_ERROR}, 8'h00);
    rd(15'h7FFF, 8'hA5);
    rd(15'h0000, 8'hFF);
  endtask
  task t_page;
    send(2'h1, 15'h0900, 8'h11, 1'b0);
    send(2'h1, 15'h097F, 8'h80, 1'b0);
    send(2'h1, 15'h0905, 8'h3C, 1'b0);
    tick(100);
    check({7'h00, WRITE_BUSY}, 8'h00);
    wait_busy(1'b1, 400);
    wait_busy(1'b0, 3000);
    rd(15'h0900, 8'h11);
    rd(15'h097F, 8'h80);
    rd(15'h0905, 8'h3C);
  endtask
  task t_refuse;
    // The read is held off until programming of the byte ends
    send(2'h1, 15'h0100, 8'h5A, 1'b1);
    wait_busy(1'b1, 400);
    check({7'h00, REQ_READY}, 8'h00);
    rd(15'h0100, 8'h5A);
    check({7'h00, WRITE_BUSY}, 8'h00);
  endtask
  initial begin
    RST = 1'b1;
    {REQ_VALID, REQ_LAST, REQ_OP, REQ_ADDR, REQ_DATA} = '0;
    tick(4);
    t_reset;
    RST = 1'b0;
    tick(1);
    t_byte;
    t_page;
    t_refuse;
    check({7'h00, viol}, 8'h00);
    test_done;
  end
endmodule
